// ### verilog/ranging_params.svh
/*
  Constants for the ranging sensor target-side control block.
  Assumes inclusion by bare name from design files under verilog/.
*/
`ifndef RANGING_PARAMS_SVH
`define RANGING_PARAMS_SVH

// ==========================================================================
// Bus addressing
// ==========================================================================
`define TGT_ADDR7          7'h29
`define ADDR_BITS          16
`define REG_DEPTH_LOG2     8

// ==========================================================================
// Timing
// ==========================================================================
`define CLK_PERIOD_NS      10
`define BOOT_TIME_NS       1200000
`define BOOT_CYCLES        (`BOOT_TIME_NS / `CLK_PERIOD_NS)
`define RANGE_TIME_NS      33000000
`define RANGE_CYCLES       (`RANGE_TIME_NS / `CLK_PERIOD_NS)
`define CALIB_CYCLES       1000

// ==========================================================================
// Result register layout
// ==========================================================================
`define RES_STATUS_IDX     16'h0089
`define RES_DIST_IDX       16'h0096
`define RES_IRQ_CLR_IDX    16'h0086
`define RES_MODE_IDX       16'h0087
`define MODE_START         8'h40
`define MODE_STOP          8'h00
`define STATUS_OK          8'h09
`define STATUS_NO_TARGET   8'h04

`endif

// ### verilog/ranging_pkg.sv
/*
  Types shared by the ranging sensor control block.
  Assumes ranging_params.svh is available on the include path.
*/
package ranging_pkg;

  // Power and ranging states, one-hot.
  typedef enum logic [5:0] {
    PWR_HW_STBY = 6'h01,
    PWR_BOOT    = 6'h02,
    PWR_SW_STBY = 6'h04,
    PWR_CALIB   = 6'h08,
    PWR_RANGING = 6'h10,
    PWR_HOLD    = 6'h20
  } pwr_state_t;

  // Serial target states, one-hot.
  typedef enum logic [4:0] {
    BUS_IDLE  = 5'h01,
    BUS_ADDR  = 5'h02,
    BUS_WRITE = 5'h04,
    BUS_READ  = 5'h08,
    BUS_IGNORE = 5'h10
  } bus_state_t;

endpackage

// ### verilog/ranging_ctrl.sv
/*
  Target-side serial control and power/ranging sequencing of a ranging
  sensor. Assumes a host master drives the bus clock and shutdown pin and
  that the board supplies pull-ups on both bus lines and the interrupt pin.
*/
// What this block does
// - Answer only bus address 0x29, as write 0x52 or read 0x53.
// - Address LSB selects write or read.
// - Only pull lines low, else release.
// - Eight-bit bytes, each followed by acknowledge.
// - Sample data on rising bus clock.
// - Data edges during clock high frame.
// - Acknowledge match and latch direction bit.
// - Write carries sixteen-bit register index.
// - Store received byte at current index.
// - Read sends indexed register bits, one per fall.
// - Receiver of each byte acknowledges it.
// - Index increments after every data byte.
// - Bus runs up to one megabit.
// - Shutdown low holds standby; boot 1.2ms.
// - Tied-high shutdown boots straight to standby.
// - START calibrates then ranges; STOP returns.
// - Ranging repeats every 33 ms.
// - Completed measurement pulls interrupt pin low.
// - Hold ranging until host clears interrupt.
// - No target gives readable status code.
// - Multi-byte values ascend, MSB lowest address.
// - Interrupt pin is open drain.
// - Shutdown pin is active low.
`timescale 1ns/1ps
`include "ranging_params.svh"

module ranging_ctrl
  import ranging_pkg::*;
#(
  parameter int BOOT_CYC  = `BOOT_CYCLES,   // Boot length in mclk cycles.
  parameter int RANGE_CYC = `RANGE_CYCLES,  // One ranging period.
  parameter int CALIB_CYC = `CALIB_CYCLES,  // Self-calibration length.
  parameter int DEPTH_LOG2 = `REG_DEPTH_LOG2 // Register file size, log2.
)(
  input  wire logic        mclk,            // System clock, 100 MHz.
  input  wire logic        arst_n,          // Async reset, active low.
  input  wire logic        scl_clk,         // Bus clock as a clock port.
  input  wire logic        sda_i,           // Bus data level.
  output logic             sda_o,           // Always low when enabled.
  output logic             sda_oe,          // High while pulling low.
  input  wire logic        shutdown_n_pin,  // Shutdown, active low.
  input  wire logic        main_supply,     // Main supply present.
  input  wire logic        target_seen,     // Optics found a target.
  input  wire logic [15:0] target_dist,     // Distance from optics.
  output logic             result_irq_pin_o,  // Always low when enabled.
  output logic             result_irq_pin_oe, // High while pulling low.
  output logic             ready            // Software standby or later.
);

  localparam int DEPTH = 1 << DEPTH_LOG2;

  // ==========================================================================
  // Reset release and pin synchronisers (mclk domain)
  // ==========================================================================
  logic       rst_s1_r, rst_n_r;          // Reset release pair.
  logic [1:0] shut_sync_r;                // Shutdown pin synchroniser.
  logic [1:0] sup_sync_r;                 // Supply level synchroniser.

  // Reset is released through two flip-flops so that deassertion is clean.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // Two-flop synchronisers for asynchronous pin levels.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      shut_sync_r <= 2'b00;
      sup_sync_r  <= 2'b00;
    end else begin
      shut_sync_r <= {shut_sync_r[0], shutdown_n_pin};
      sup_sync_r  <= {sup_sync_r[0], main_supply};
    end
  end

  wire awake = shut_sync_r[1] & sup_sync_r[1];

  // ==========================================================================
  // Link-domain reset: bus logic is held while the device is not ready
  // ==========================================================================
  logic       ready_r;                    // Device answers the bus.
  logic [1:0] lrst_sync_r;                // Ready level into scl domain.
  wire        lrst_n = lrst_sync_r[1];

  // The link logic is reset at once by the async reset arst_n as well, so a
  // half-finished frame never survives a reset.
  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      lrst_sync_r <= 2'b00;
    end else begin
      lrst_sync_r <= {lrst_sync_r[0], ready_r};
    end
  end

  // ==========================================================================
  // Register file, written from the link domain
  // ==========================================================================
  logic [7:0]  regs_r [DEPTH];            // Byte registers.
  logic [15:0] index_r;                   // Current register index.
  logic [7:0]  shift_r;                   // Serial/parallel register.
  logic [3:0]  bit_cnt_r;                 // Bit position, 8 = ack slot.
  logic        dir_rd_r;                  // Latched direction bit.
  logic [1:0]  idx_bytes_r;               // Index bytes received so far.
  bus_state_t  bus_r;                     // Serial target state.
  logic        ack_drv_r;                 // Pull data low for ack.
  logic        tx_drv_r;                  // Pull data low for a zero bit.
  logic        wr_tgl_r;                  // Toggles on each stored byte.
  logic [15:0] wr_idx_r;                  // Index of last stored byte.
  logic [7:0]  wr_dat_r;                  // Value of last stored byte.

  // Start and stop are seen as data edges with the bus clock high; they are
  // detected on the data line, so they are kept as flags that the clocked
  // bus logic consumes on its next edge.
  logic start_tgl_r, stop_tgl_r;          // Toggled by data edges.
  logic start_seen_r, stop_seen_r;        // Last consumed toggles.

  // Data falling while the clock is high marks a start.
  always_ff @(negedge sda_i or negedge lrst_n) begin
    if (!lrst_n) begin
      start_tgl_r <= 1'b0;
    end else if (scl_clk) begin
      start_tgl_r <= ~start_tgl_r;
    end
  end

  // Data rising while the clock is high marks a stop.
  always_ff @(posedge sda_i or negedge lrst_n) begin
    if (!lrst_n) begin
      stop_tgl_r <= 1'b0;
    end else if (scl_clk) begin
      stop_tgl_r <= ~stop_tgl_r;
    end
  end

  wire start_ev = start_tgl_r ^ start_seen_r;
  wire stop_ev  = stop_tgl_r ^ stop_seen_r;

  // Reads of the result registers see live state from mclk registers,
  // passed in through the register file copy below.
  function automatic logic [DEPTH_LOG2-1:0] slot(input logic [15:0] idx);
    slot = idx[DEPTH_LOG2-1:0];
  endfunction

  // Receive path: all serial data is sampled on the rising bus clock.
  always_ff @(posedge scl_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      bus_r        <= BUS_IDLE;
      shift_r      <= 8'h00;
      bit_cnt_r    <= 4'h0;
      dir_rd_r     <= 1'b0;
      idx_bytes_r  <= 2'b00;
      index_r      <= 16'h0000;
      start_seen_r <= 1'b0;
      stop_seen_r  <= 1'b0;
      wr_tgl_r     <= 1'b0;
      wr_idx_r     <= 16'h0000;
      wr_dat_r     <= 8'h00;
    end else begin
      start_seen_r <= start_tgl_r;
      stop_seen_r  <= stop_tgl_r;
      if (start_ev) begin
        // A start or repeated start always opens a new address byte.
        bus_r     <= BUS_ADDR;
        shift_r   <= {7'h00, sda_i};
        bit_cnt_r <= 4'h1;
      end else if (stop_ev) begin
        bus_r <= BUS_IDLE;
      end else if (bit_cnt_r == 4'h8) begin
        // Acknowledge slot: decide what the finished byte means.
        bit_cnt_r <= 4'h0;
        case (bus_r)
          BUS_ADDR: begin
            if (shift_r[7:1] == `TGT_ADDR7) begin
              dir_rd_r    <= shift_r[0];
              bus_r       <= shift_r[0] ? BUS_READ : BUS_WRITE;
              idx_bytes_r <= 2'b00;
            end else begin
              bus_r <= BUS_IGNORE;
            end
          end
          BUS_WRITE: begin
            if (idx_bytes_r != 2'b10) begin
              index_r     <= {index_r[7:0], shift_r};
              idx_bytes_r <= idx_bytes_r + 2'b01;
            end else begin
              wr_idx_r <= index_r;
              wr_dat_r <= shift_r;
              wr_tgl_r <= ~wr_tgl_r;
              index_r  <= index_r + 16'h0001;
            end
          end
          BUS_READ: begin
            // A high host acknowledge ends the read.
            if (sda_i) begin
              bus_r <= BUS_IGNORE;
            end
            index_r <= index_r + 16'h0001;
          end
          default: begin
            bus_r <= bus_r;
          end
        endcase
      end else begin
        shift_r   <= {shift_r[6:0], sda_i};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
  end

  // Transmit path: data changes on the falling bus clock.
  always_ff @(negedge scl_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      ack_drv_r <= 1'b0;
      tx_drv_r  <= 1'b0;
    end else begin
      ack_drv_r <= 1'b0;
      tx_drv_r  <= 1'b0;
      if (bit_cnt_r == 4'h8 && !start_ev && !stop_ev) begin
        if (bus_r == BUS_ADDR) begin
          ack_drv_r <= (shift_r[7:1] == `TGT_ADDR7);
        end else if (bus_r == BUS_WRITE) begin
          ack_drv_r <= 1'b1;
        end
      end else if (dir_rd_r && bus_r == BUS_READ && bit_cnt_r != 4'h8) begin
        // Bit of the indexed register taken directly on each fall, MSB first.
        tx_drv_r <= ~regs_r[slot(index_r)][3'(7 - bit_cnt_r)];
      end
    end
  end

  // Open drain: only ever pull low, otherwise release.
  assign sda_o  = 1'b0;
  assign sda_oe = ack_drv_r | tx_drv_r;

  // ==========================================================================
  // Crossing of stored bytes into the mclk domain (toggle handshake)
  // ==========================================================================
  logic [2:0] wr_sync_r;                  // Toggle synchroniser.
  wire        wr_ev = wr_sync_r[2] ^ wr_sync_r[1];

  // The index and data are stable for many mclk cycles after the toggle.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wr_sync_r <= 3'b000;
    end else begin
      wr_sync_r <= {wr_sync_r[1:0], wr_tgl_r};
    end
  end

  // ==========================================================================
  // Power and ranging sequencer
  // ==========================================================================
  pwr_state_t pwr_r;                      // Power state.
  logic [31:0] tmr_r;                     // Boot, calib and range timer.
  logic       irq_r;                      // Result interrupt pending.
  logic [7:0] status_r;                   // Range status code.
  logic [15:0] dist_r;                    // Latched distance.

  wire host_start = wr_ev && wr_idx_r == `RES_MODE_IDX
                    && wr_dat_r == `MODE_START;
  wire host_stop  = wr_ev && wr_idx_r == `RES_MODE_IDX
                    && wr_dat_r == `MODE_STOP;
  wire host_clr   = wr_ev && wr_idx_r == `RES_IRQ_CLR_IDX;

  // Sequencer: standby, boot, software standby, calibration and ranging.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pwr_r    <= PWR_HW_STBY;
      tmr_r    <= 32'h0000_0000;
      irq_r    <= 1'b0;
      status_r <= 8'h00;
      dist_r   <= 16'h0000;
    end else if (!awake) begin
      pwr_r <= PWR_HW_STBY;
      irq_r <= 1'b0;
      tmr_r <= 32'h0000_0000;
    end else begin
      tmr_r <= tmr_r + 32'h0000_0001;
      case (pwr_r)
        PWR_HW_STBY: begin
          pwr_r <= PWR_BOOT;
          tmr_r <= 32'h0000_0000;
        end
        PWR_BOOT: begin
          if (tmr_r >= 32'(BOOT_CYC - 1)) begin
            pwr_r <= PWR_SW_STBY;
          end
        end
        PWR_SW_STBY: begin
          if (host_start) begin
            pwr_r <= PWR_CALIB;
            tmr_r <= 32'h0000_0000;
          end
        end
        PWR_CALIB: begin
          if (host_stop) begin
            pwr_r <= PWR_SW_STBY;
          end else if (tmr_r >= 32'(CALIB_CYC - 1)) begin
            pwr_r <= PWR_RANGING;
            tmr_r <= 32'h0000_0000;
          end
        end
        PWR_RANGING: begin
          if (host_stop) begin
            pwr_r <= PWR_SW_STBY;
          end else if (tmr_r >= 32'(RANGE_CYC - 1)) begin
            irq_r    <= 1'b1;
            dist_r   <= target_dist;
            status_r <= target_seen ? `STATUS_OK
                                    : `STATUS_NO_TARGET;
            pwr_r    <= PWR_HOLD;
          end
        end
        PWR_HOLD: begin
          if (host_stop) begin
            pwr_r <= PWR_SW_STBY;
            irq_r <= 1'b0;
          end else if (host_clr) begin
            irq_r <= 1'b0;
            pwr_r <= PWR_RANGING;
            tmr_r <= 32'h0000_0000;
          end
        end
        default: begin
          pwr_r <= PWR_HW_STBY;
        end
      endcase
    end
  end

  // Bus answers only once software standby is reached.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= awake && pwr_r != PWR_HW_STBY
                 && pwr_r != PWR_BOOT;
    end
  end

  // ==========================================================================
  // Register file storage, updated in mclk; results overlay host writes
  // ==========================================================================
  // Host writes land here; results are placed big-endian at their indices.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int i = 0; i < DEPTH; i++) begin
        regs_r[i] <= 8'h00;
      end
    end else begin
      if (wr_ev) begin
        regs_r[slot(wr_idx_r)] <= wr_dat_r;
      end
      regs_r[slot(`RES_STATUS_IDX)]          <= status_r;
      regs_r[slot(`RES_DIST_IDX)]            <= dist_r[15:8];
      regs_r[slot(`RES_DIST_IDX + 16'h0001)] <= dist_r[7:0];
      regs_r[slot(`RES_IRQ_CLR_IDX)]         <= {7'h00, irq_r};
    end
  end

  assign result_irq_pin_o  = 1'b0;
  assign result_irq_pin_oe = irq_r;
  assign ready             = ready_r;

endmodule

// ### tb/ranging_ctrl_props.sv
/*
  Port checker for the ranging sensor control block.
  Assumes it is bound to every ranging_ctrl instance and sees only ports.
*/
`timescale 1ns/1ps
module ranging_ctrl_props #(
  parameter int BOOT_CYC  = 20,  // Boot length in mclk cycles.
  parameter int RANGE_CYC = 200  // One ranging period in mclk cycles.
)(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic scl_clk,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic shutdown_n_pin,
  input wire logic main_supply,
  input wire logic result_irq_pin_o,
  input wire logic result_irq_pin_oe,
  input wire logic ready
);
  // ========================================================================
  // Helper counters
  // ========================================================================
  int up_r;   // Cycles with supply present and shutdown released.
  int gap_r;  // Cycles since the interrupt pin was last released.

  // Saturating counters keep the comparisons free of wrap-around.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      up_r <= 0;
    end else if (!(shutdown_n_pin && main_supply)) begin
      up_r <= 0;
    end else if (up_r < 1000000) begin
      up_r <= up_r + 1;
    end
  end

  // Counts from the release of the pin, so a rise can be timed.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gap_r <= 1000000;
    end else if (result_irq_pin_oe) begin
      gap_r <= 0;
    end else if (gap_r < 1000000) begin
      gap_r <= gap_r + 1;
    end
  end

  // ========================================================================
  // Assertions
  // ========================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_sda_low; sda_oe |-> !sda_o; endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data line driven high");
  property p_irq_low; result_irq_pin_oe |-> !result_irq_pin_o; endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt pin driven high");
  property p_shut_hold; !shutdown_n_pin [*5] |-> !ready; endproperty
  a_shut_hold: assert property (p_shut_hold)
    else $error("ready while shutdown low");
  property p_no_ack; !ready [*8] |-> !sda_oe; endproperty
  a_no_ack: assert property (p_no_ack)
    else $error("data pulled while not ready");
  property p_boot_min; $rose(ready) |-> up_r >= BOOT_CYC; endproperty
  a_boot_min: assert property (p_boot_min)
    else $error("boot too short");
  property p_boot_max; up_r == BOOT_CYC + 12 |-> ready; endproperty
  a_boot_max: assert property (p_boot_max)
    else $error("boot too long");
  property p_irq_ready; $rose(result_irq_pin_oe) |-> ready; endproperty
  a_irq_ready: assert property (p_irq_ready)
    else $error("interrupt while not ready");
  property p_irq_gap;
    $rose(result_irq_pin_oe) |-> gap_r >= RANGE_CYC - 8;
  endproperty
  a_irq_gap: assert property (p_irq_gap)
    else $error("ranging period too short");
  property p_sda_stable;
    scl_clk && $past(scl_clk) |-> $stable(sda_oe);
  endproperty
  a_sda_stable: assert property (p_sda_stable)
    else $error("data changed while clock high");
  property p_irq_stays;
    $rose(result_irq_pin_oe) |-> result_irq_pin_oe [*8];
  endproperty
  a_irq_stays: assert property (p_irq_stays)
    else $error("interrupt dropped early");
endmodule

bind ranging_ctrl ranging_ctrl_props #(
  .BOOT_CYC(BOOT_CYC),
  .RANGE_CYC(RANGE_CYC)
) u_props (
  .mclk(mclk),
  .arst_n(arst_n),
  .scl_clk(scl_clk),
  .sda_o(sda_o),
  .sda_oe(sda_oe),
  .shutdown_n_pin(shutdown_n_pin),
  .main_supply(main_supply),
  .result_irq_pin_o(result_irq_pin_o),
  .result_irq_pin_oe(result_irq_pin_oe),
  .ready(ready)
);

// ### tb/host_model.sv
/*
  Behavioural two-wire bus master with a 64 ns bit clock.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
module host_model (
  output logic      scl,      // Bus clock, idle high.
  output logic      sda_low,  // High while the host pulls data low.
  input  wire logic sda       // Resolved data wire level.
);
  // Clock driven high and data released at idle, so the pull-up holds data high.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // One bit slot: data moves in the low phase, sampled mid high phase.
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b; // Only pulls low, otherwise releases.
    #16 scl = 1'b1; // The host makes every clock pulse.
    #16 r = sda;
    #16 scl = 1'b0;
    #16;
  endtask

  // Data falls with the clock high; the clock stops low after it.
  task automatic start();
    sda_low = 1'b0;
    #16 scl = 1'b1;
    #16 sda_low = 1'b1;
    #16 scl = 1'b0;
    #16;
  endtask

  // Data rises with the clock high, ending the message.
  task automatic stop();
    sda_low = 1'b1;
    #16 scl = 1'b1;
    #16 sda_low = 1'b0;
    #32;
  endtask

  // Eight bits, most significant first, then the target's ack slot.
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // The host acks each byte and leaves the last one high.
  task automatic rd(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask

  // Two clocks with data released let the bus logic leave reset.
  task automatic dummy();
    repeat (2) begin
      #16 scl = 1'b0;
      #32 scl = 1'b1;
      #16;
    end
  endtask
endmodule

// ### tb/tb.sv
/*
  Self-checking bench for the ranging sensor control block.
  Assumes host_model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module tb;
  localparam int BOOT = 20;    // Shortened boot.
  localparam int RNG  = 3000;  // Shortened ranging period.
  localparam int CAL  = 10;    // Shortened calibration.
  logic mclk = 0, arst_n = 1, shutdown_n_pin = 0, main_supply = 1;
  logic target_seen = 0, a;
  logic [15:0] target_dist = 16'h0000, idx;
  logic [31:0] r;
  logic [7:0] wbuf[4], rbuf[4];
  wire scl, host_low, sda_o, sda_oe, irq_o, irq_oe, ready;
  wire sda = !(sda_oe && !sda_o) && !host_low;  // Pull-up resolution.
  int num_errors = 0, checked = 0, cycles = 0, seed = 55, n;

  always #5 mclk = ~mclk;

  ranging_ctrl #(.BOOT_CYC(BOOT), .RANGE_CYC(RNG), .CALIB_CYC(CAL),
    .DEPTH_LOG2(8)) DUT (.mclk(mclk), .arst_n(arst_n), .scl_clk(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .shutdown_n_pin(shutdown_n_pin), .main_supply(main_supply),
    .target_seen(target_seen), .target_dist(target_dist),
    .result_irq_pin_o(irq_o), .result_irq_pin_oe(irq_oe), .ready(ready));
  host_model host (.scl(scl), .sda_low(host_low), .sda(sda));

  // ========================================================================
  // Checking and closing
  // ========================================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // A hung handshake ends the run here rather than never.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      $display("MISMATCH at %0t: timeout", $time);
      close_out();
    end
  end

  function automatic logic [7:0] status_of(input logic seen);
    return seen ? 8'h09 : 8'h04;
  endfunction

  // ========================================================================
  // Message tasks
  // ========================================================================
  task automatic open_msg(input logic [15:0] i);
    host.start();
    host.wr(8'h52, a);
    check(a, 1, "address ack"); // Own address taken.
    host.wr(i[15:8], a);
    check(a, 1, "index ack"); // Upper index byte first.
    host.wr(i[7:0], a);
    check(a, 1, "index ack"); // Lower index byte.
  endtask

  task automatic wmsg(input logic [15:0] i, input int cnt);
    open_msg(i);
    for (int k = 0; k < cnt; k++) begin
      host.wr(wbuf[k], a);
      check(a, 1, "data ack"); // Each data byte acked.
    end
    host.stop();
  endtask

  task automatic rmsg(input logic [15:0] i, input int cnt);
    open_msg(i);
    host.start();
    host.wr(8'h53, a);
    check(a, 1, "read address ack"); // Direction bit set.
    for (int k = 0; k < cnt; k++) host.rd(rbuf[k], k == cnt - 1);
    host.stop();
  endtask

  task automatic wait_irq(input logic lvl, input int lim);
    for (n = 0; n < lim && irq_oe !== lvl; n++) @(negedge mclk);
  endtask

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial begin
    // A real falling edge, so the link-clock flops are reset as well.
    #1 arst_n = 0;
    repeat (3) @(negedge mclk);
    arst_n = 1;
    repeat (40) @(negedge mclk);
    check(ready, 0, "ready in standby"); // Held by low pin.
    host.start();
    host.wr(8'h52, a);
    host.stop();
    check(a, 0, "ack in standby"); // Silent while not booted.
    $display("test standby done");
    @(negedge mclk) shutdown_n_pin = 1; // Raised with the bus idle.
    for (n = 0; n < BOOT + 40 && ready !== 1'b1; n++) @(negedge mclk);
    check(ready, 1, "boot end"); // Boot completes in time.
    check(n >= BOOT, 1, "boot length"); // Not before the boot time.
    host.dummy();
    repeat (4) begin
      r = $random(seed);
      if (r[7:1] == 7'h29) r[7:1] = 7'h2A;
      host.start();
      host.wr(r[7:0], a);
      host.stop();
      check(a, 0, "foreign address"); // Other addresses ignored.
    end
    $display("test address done");
    r = $random(seed);
    idx = 16'h0020 + {10'h000, r[5:0]};
    for (int k = 0; k < 4; k++) wbuf[k] = 8'($random(seed));
    wmsg(idx, 4);
    rmsg(idx, 4);
    for (int k = 0; k < 4; k++)
      check(rbuf[k], wbuf[k], "burst data");
    rmsg(idx + 16'd2, 1);
    check(rbuf[0], wbuf[2], "indexed read"); // Index advanced by two.
    $display("test burst done");
    @(negedge mclk);
    target_seen = 1;
    target_dist = r[23:8];
    wbuf[0] = 8'h40;
    wmsg(16'h0087, 1);
    wait_irq(1, CAL + RNG + 500);
    check(irq_oe, 1, "result irq"); // Start leads to a result.
    rmsg(16'h0089, 1);
    check(rbuf[0], status_of(1), "status ok"); // Result readable.
    rmsg(16'h0096, 2);
    check({rbuf[0], rbuf[1]}, target_dist, "distance"); // MSB low.
    repeat (RNG + 100) @(negedge mclk);
    check(irq_oe, 1, "irq held"); // Ranging waits for the host.
    target_seen = 0;
    wbuf[0] = 8'h00;
    wmsg(16'h0086, 1);
    wait_irq(0, 50);
    check(irq_oe, 0, "irq cleared"); // Clear releases the pin.
    wait_irq(1, RNG + 500);
    check(irq_oe, 1, "next result"); // Next range restarts itself.
    rmsg(16'h0089, 1);
    check(rbuf[0], status_of(0), "no target"); // Error code readable.
    wmsg(16'h0086, 1);
    wmsg(16'h0087, 1);
    repeat (2 * RNG) @(negedge mclk);
    check(irq_oe, 0, "stopped"); // Stop returns to standby.
    check(ready, 1, "still ready"); // Software standby kept.
    main_supply = 0; // Supply lost: back to standby until it returns.
    repeat (8) @(negedge mclk);
    check(ready, 0, "supply lost"); // No supply, no service.
    main_supply = 1;
    $display("test ranging done");
    arst_n = 0;
    repeat (3) @(negedge mclk);
    arst_n = 1;
    for (n = 0; n < BOOT + 40 && ready !== 1'b1; n++) @(negedge mclk);
    check(ready, 1, "tied high boot"); // Straight to standby.
    $display("test tied high done");
    close_out();
  end
endmodule
